// ===== common/ledbk_pkg.sv
package ledbk_pkg;

    // Link status from the rest of the device
    typedef struct packed {
        logic link_up;
        logic speed_100;
        logic full_duplex;
        logic collision;
        logic tx_active;
        logic rx_active;
    } ledbk_phy_t;

    // Override selections
    typedef enum logic [1:0] {
        LEDBK_OVR_OFF = 2'b00,
        LEDBK_OVR_ON = 2'b01,
        LEDBK_OVR_MODE1 = 2'b10,
        LEDBK_OVR_MODE2 = 2'b11
    } ledbk_ovr_t;

endpackage

// ===== common/ledbk_regs.svh
`ifndef LEDBK_REGS_SVH
`define LEDBK_REGS_SVH

// Register indices; byte address is four times the index
`define LEDBK_IDX_COMMON 16'h40c1
`define LEDBK_IDX_RATE 16'h40c2
`define LEDBK_IDX_CTRL 16'h40c3
`define LEDBK_IDX_STATUS 16'h40c4

// Reset values
`define LEDBK_RATE_RST 16'hec75
`define LEDBK_CTRL_RST 16'h0310
`define LEDBK_COMMON_RST 16'h000c

// Blink-rate field positions (low bit of each 4-bit field)
`define LEDBK_RATE_M0_LSB 12
`define LEDBK_RATE_M1_LSB 8
`define LEDBK_RATE_M2_LSB 4
`define LEDBK_RATE_M3_LSB 0

// Second indicator control field positions
`define LEDBK_CTRL_OVR_ON 15
`define LEDBK_CTRL_OVR_SEL_LSB 13
`define LEDBK_CTRL_POLICY 12
`define LEDBK_CTRL_FDX_LIT 11
`define LEDBK_CTRL_HDX_LIT 10
`define LEDBK_CTRL_TX_BLINK 9
`define LEDBK_CTRL_RX_BLINK 8
`define LEDBK_CTRL_TX_LIT 7
`define LEDBK_CTRL_RX_LIT 6
`define LEDBK_CTRL_FAST_LIT 5
`define LEDBK_CTRL_SLOW_LIT 4
`define LEDBK_CTRL_COL_BLINK 3
`define LEDBK_CTRL_FAST_BLINK 2
`define LEDBK_CTRL_SLOW_BLINK 1
`define LEDBK_CTRL_WMASK 16'hfffe

// Common control field positions
`define LEDBK_COM_REVERSE 9
`define LEDBK_COM_HEAVY_EN 5
`define LEDBK_COM_WMASK 16'h023f

// Timing: base tick of 1 ms at a 10 ns clock
`define LEDBK_TICK_NS 1000000
`define LEDBK_CLK_NS 10
`define LEDBK_HOLD_MS 10
`define LEDBK_WINDOW_MS 1000
`define LEDBK_HEAVY_UNIT_MS 42

`endif

// ===== hw/ledbk_top.sv
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`include "ledbk_regs.svh"
// Notes on behaviour
// - Rate field 15:12 sets blink mode 0 timing, reset 0xE.
// - Rate field 11:8 sets blink mode 1 timing, reset 0xC.
// - Rate field 7:4 sets blink mode 2 timing, reset 0x7.
// - Rate field 3:0 sets blink mode 3 timing, reset 0x5.
// - Codes 0-4: periods 10, 9.4, 8, 7.4, 6 s; off 6-11 percent.
// - Codes 5,6,7,9: periods 4, 3, 2, 1 s; off 8,11,16,16 percent.
// - Codes 10,11,12,13,15: 2,3,4,8,8 Hz with equal on and off.
// - Off shares hold with reverse clear; reverse set swaps on and off.
// - Control bit 15 enables override of the second indicator, reset 0.
// - Override field 14:13: off, on, mode 1 blink, mode 2 blink.
// - Bit 12: traffic blinks always, or only when already lit.
// - Bit 11 lights indicator on link up in full duplex.
// - Bit 10 lights indicator on link up in half duplex.
// - Bits 9 and 8 blink on transmit or receive activity: mode 2, or mode 1 with heavy option on.
// - Bits 7 and 6 light on activity, held at least 10 ms.
// - Bit 5 lights indicator on link up at 100 Mb/s.
// - Bit 4 lights indicator on link up at 10 Mb/s, reset 1.
// - Bit 3 blinks indicator on collision with link up.
// - Bits 2 and 1 blink on link up at 100 or 10 Mb/s.
// - Control bit 0 reads zero and ignores writes.
// - Reverse bit makes on time short and off time long.
// - Heavy traffic with option on uses mode 0 for activity blink.
// - Each direction measured per 1 s; heavy above threshold times 42 ms.
module ledbk_top #(
    parameter int TICK_CYCLES = `LEDBK_TICK_NS / `LEDBK_CLK_NS
) (
    input wire logic CLK, // 100 MHz clock
    input wire logic RESET_N, // Asynchronous reset
    input wire logic PSEL, // APB select
    input wire logic PENABLE, // APB access phase
    input wire logic PWRITE, // APB direction
    input wire logic [17:0] PADDR, // APB byte address
    input wire logic [31:0] PWDATA, // APB write data
    output logic [31:0] PRDATA, // APB read data
    output logic PREADY, // APB ready
    output logic PSLVERR, // APB error, unmapped address
    input wire ledbk_pkg::ledbk_phy_t PHY_STATUS, // Link status, same clock
    output logic IND_B_LIT // Second indicator, high lit
);
    import ledbk_pkg::*;

    // Blink period in ms for a rate code
    function automatic logic [13:0] rate_period(input logic [3:0] code);
        case (code)
            4'h0: rate_period = 14'd10000;
            4'h1: rate_period = 14'd9400;
            4'h2: rate_period = 14'd8000;
            4'h3: rate_period = 14'd7400;
            4'h4: rate_period = 14'd6000;
            4'h5: rate_period = 14'd4000;
            4'h6: rate_period = 14'd3000;
            4'h7, 4'h8: rate_period = 14'd2000;
            4'h9: rate_period = 14'd1000;
            4'ha: rate_period = 14'd500;
            4'hb: rate_period = 14'd333;
            4'hc: rate_period = 14'd250;
            default: rate_period = 14'd125;
        endcase
    endfunction

    // Off portion in ms for a rate code
    function automatic logic [13:0] rate_off(input logic [3:0] code);
        case (code)
            4'h0: rate_off = 14'd600;
            4'h1: rate_off = 14'd658;
            4'h2: rate_off = 14'd640;
            4'h3: rate_off = 14'd666;
            4'h4: rate_off = 14'd660;
            4'h5: rate_off = 14'd320;
            4'h6: rate_off = 14'd330;
            4'h7, 4'h8: rate_off = 14'd320;
            4'h9: rate_off = 14'd160;
            4'ha: rate_off = 14'd250;
            4'hb: rate_off = 14'd167;
            4'hc: rate_off = 14'd125;
            default: rate_off = 14'd63;
        endcase
    endfunction

    // Heavy verdict for one direction
    function automatic logic is_heavy(input logic [9:0] active_ms, input logic [4:0] thr);
        logic [10:0] limit;
        limit = 11'(thr) * 11'(`LEDBK_HEAVY_UNIT_MS);
        is_heavy = 11'(active_ms) > limit;
    endfunction

    logic [15:0] rate_r;
    logic [15:0] ctrl_r;
    logic [15:0] common_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic ind_r;
    logic [31:0] tick_cnt_r;
    logic tick_r;
    logic [13:0] phase_r [4];
    logic [3:0] mode_lit;
    logic [3:0] tx_hold_r;
    logic [3:0] rx_hold_r;
    logic [9:0] win_r;
    logic tx_seen_r;
    logic rx_seen_r;
    logic [9:0] tx_ms_r;
    logic [9:0] rx_ms_r;
    logic heavy_tx_r;
    logic heavy_rx_r;
    logic ind_nxt;

    logic [15:0] rd_word;
    logic rd_hit;
    logic wr_take;
    logic [15:0] status_word;

    // Register access decode
    always_comb
    begin
        rd_word = 16'h0000;
        rd_hit = 1'b1;
        if (PADDR == {`LEDBK_IDX_RATE, 2'b00})
        begin
            rd_word = rate_r;
        end
        else if (PADDR == {`LEDBK_IDX_CTRL, 2'b00})
        begin
            rd_word = ctrl_r & `LEDBK_CTRL_WMASK;
        end
        else if (PADDR == {`LEDBK_IDX_COMMON, 2'b00})
        begin
            rd_word = common_r;
        end
        else if (PADDR == {`LEDBK_IDX_STATUS, 2'b00})
        begin
            rd_word = status_word;
        end
        else
        begin
            rd_hit = 1'b0;
        end
    end

    // Live state shown to software
    assign status_word = {10'h000, PHY_STATUS.link_up, heavy_rx_r, heavy_tx_r, 2'b00, ind_r};
    assign wr_take = PSEL & PENABLE & pready_r & PWRITE & rd_hit;

    // Bus answer one cycle into the access phase
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            pready_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pready_r <= PSEL & PENABLE & ~pready_r;
            if (PSEL & PENABLE & ~pready_r)
            begin
                prdata_r <= PWRITE ? 32'h0000_0000 : {16'h0000, rd_word};
                pslverr_r <= ~rd_hit;
            end
            else
            begin
                prdata_r <= 32'h0000_0000;
                pslverr_r <= 1'b0;
            end
        end
    end

    // Blink-rate register
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            rate_r <= `LEDBK_RATE_RST;
        end
        else if (wr_take && PADDR == {`LEDBK_IDX_RATE, 2'b00})
        begin
            rate_r <= PWDATA[15:0];
        end
    end

    // Second indicator control register
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            ctrl_r <= `LEDBK_CTRL_RST;
        end
        else if (wr_take && PADDR == {`LEDBK_IDX_CTRL, 2'b00})
        begin
            ctrl_r <= PWDATA[15:0] & `LEDBK_CTRL_WMASK;
        end
    end

    // Common control register
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            common_r <= `LEDBK_COMMON_RST;
        end
        else if (wr_take && PADDR == {`LEDBK_IDX_COMMON, 2'b00})
        begin
            common_r <= PWDATA[15:0] & `LEDBK_COM_WMASK;
        end
    end

    // Millisecond tick
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            tick_cnt_r <= 32'h0000_0000;
            tick_r <= 1'b0;
        end
        else if (tick_cnt_r >= 32'(TICK_CYCLES - 1))
        begin
            tick_cnt_r <= 32'h0000_0000;
            tick_r <= 1'b1;
        end
        else
        begin
            tick_cnt_r <= tick_cnt_r + 32'h1;
            tick_r <= 1'b0;
        end
    end

    // Phase counters of the four blink modes
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            for (int m = 0; m < 4; m++)
            begin
                phase_r[m] <= 14'h0000;
            end
        end
        else if (tick_r)
        begin
            for (int m = 0; m < 4; m++)
            begin
                if (phase_r[m] >= rate_period(rate_r[`LEDBK_RATE_M0_LSB - 4 * m +: 4]) - 14'h1)
                begin
                    phase_r[m] <= 14'h0000;
                end
                else
                begin
                    phase_r[m] <= phase_r[m] + 14'h1;
                end
            end
        end
    end

    // Lit phase of each mode, off portion first with reverse clear, lit portion first with reverse set
    always_comb
    begin
        for (int m = 0; m < 4; m++)
        begin
            if (common_r[`LEDBK_COM_REVERSE])
            begin
                mode_lit[m] = phase_r[m] < rate_off(rate_r[`LEDBK_RATE_M0_LSB - 4 * m +: 4]);
            end
            else
            begin
                mode_lit[m] = phase_r[m] >= rate_off(rate_r[`LEDBK_RATE_M0_LSB - 4 * m +: 4]);
            end
        end
    end

    // Activity hold stretchers
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            tx_hold_r <= 4'h0;
            rx_hold_r <= 4'h0;
        end
        else
        begin
            if (PHY_STATUS.tx_active)
            begin
                tx_hold_r <= 4'(`LEDBK_HOLD_MS + 1);
            end
            else if (tick_r && tx_hold_r != 4'h0)
            begin
                tx_hold_r <= tx_hold_r - 4'h1;
            end
            if (PHY_STATUS.rx_active)
            begin
                rx_hold_r <= 4'(`LEDBK_HOLD_MS + 1);
            end
            else if (tick_r && rx_hold_r != 4'h0)
            begin
                rx_hold_r <= rx_hold_r - 4'h1;
            end
        end
    end

    // Per-direction traffic weight over one-second windows
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            win_r <= 10'h000;
            tx_seen_r <= 1'b0;
            rx_seen_r <= 1'b0;
            tx_ms_r <= 10'h000;
            rx_ms_r <= 10'h000;
            heavy_tx_r <= 1'b0;
            heavy_rx_r <= 1'b0;
        end
        else if (tick_r)
        begin
            tx_seen_r <= PHY_STATUS.tx_active;
            rx_seen_r <= PHY_STATUS.rx_active;
            if (win_r == 10'(`LEDBK_WINDOW_MS - 1))
            begin
                win_r <= 10'h000;
                heavy_tx_r <= is_heavy(tx_ms_r + 10'(tx_seen_r), common_r[4:0]);
                heavy_rx_r <= is_heavy(rx_ms_r + 10'(rx_seen_r), common_r[4:0]);
                tx_ms_r <= 10'h000;
                rx_ms_r <= 10'h000;
            end
            else
            begin
                win_r <= win_r + 10'h1;
                tx_ms_r <= tx_ms_r + 10'(tx_seen_r);
                rx_ms_r <= rx_ms_r + 10'(rx_seen_r);
            end
        end
        else
        begin
            tx_seen_r <= tx_seen_r | PHY_STATUS.tx_active;
            rx_seen_r <= rx_seen_r | PHY_STATUS.rx_active;
        end
    end

    // Indicator decision
    always_comb
    begin
        logic link;
        logic steady;
        logic act_blink;
        logic act_phase;
        logic other_blink;
        logic other_phase;
        ledbk_ovr_t sel;
        act_phase = 1'b0;
        link = PHY_STATUS.link_up;
        sel = ledbk_ovr_t'(ctrl_r[`LEDBK_CTRL_OVR_SEL_LSB +: 2]);
        steady = link & ((ctrl_r[`LEDBK_CTRL_FDX_LIT] & PHY_STATUS.full_duplex)
            | (ctrl_r[`LEDBK_CTRL_HDX_LIT] & ~PHY_STATUS.full_duplex)
            | (ctrl_r[`LEDBK_CTRL_FAST_LIT] & PHY_STATUS.speed_100)
            | (ctrl_r[`LEDBK_CTRL_SLOW_LIT] & ~PHY_STATUS.speed_100)
            | (ctrl_r[`LEDBK_CTRL_TX_LIT] & (tx_hold_r != 4'h0))
            | (ctrl_r[`LEDBK_CTRL_RX_LIT] & (rx_hold_r != 4'h0)));
        act_blink = link & ((ctrl_r[`LEDBK_CTRL_TX_BLINK] & PHY_STATUS.tx_active)
            | (ctrl_r[`LEDBK_CTRL_RX_BLINK] & PHY_STATUS.rx_active));
        act_blink = act_blink & (ctrl_r[`LEDBK_CTRL_POLICY] | steady);
        if (common_r[`LEDBK_COM_HEAVY_EN])
        begin
            act_phase = (heavy_tx_r | heavy_rx_r) ? mode_lit[0] : mode_lit[1];
        end
        else
        begin
            act_phase = mode_lit[2];
        end
        other_blink = link & ((ctrl_r[`LEDBK_CTRL_COL_BLINK] & PHY_STATUS.collision)
            | (ctrl_r[`LEDBK_CTRL_FAST_BLINK] & PHY_STATUS.speed_100)
            | (ctrl_r[`LEDBK_CTRL_SLOW_BLINK] & ~PHY_STATUS.speed_100));
        other_phase = (ctrl_r[`LEDBK_CTRL_COL_BLINK] & PHY_STATUS.collision) ? mode_lit[2] : mode_lit[3];
        if (ctrl_r[`LEDBK_CTRL_OVR_ON])
        begin
            case (sel)
                LEDBK_OVR_OFF: ind_nxt = 1'b0;
                LEDBK_OVR_ON: ind_nxt = 1'b1;
                LEDBK_OVR_MODE1: ind_nxt = mode_lit[1];
                default: ind_nxt = mode_lit[2];
            endcase
        end
        else if (act_blink)
        begin
            ind_nxt = act_phase;
        end
        else if (other_blink)
        begin
            ind_nxt = other_phase;
        end
        else
        begin
            ind_nxt = steady;
        end
    end

    // Registered indicator output
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            ind_r <= 1'b0;
        end
        else
        begin
            ind_r <= ind_nxt;
        end
    end

    assign IND_B_LIT = ind_r;
    assign PRDATA = prdata_r;
    assign PREADY = pready_r;
    assign PSLVERR = pslverr_r;

endmodule

// ===== verification/ledbk_lamp_model.sv
`timescale 1ns/1ps
module ledbk_lamp_model (
    input wire logic clk, // Clock
    input wire logic reset_n, // Reset
    input wire logic lamp_lit, // Indicator drive
    output logic [31:0] lit_len, // Last complete lit run
    output logic [31:0] dark_len, // Last complete dark run
    output logic [31:0] edges // Transitions seen
);
    logic [31:0] run_r;
    logic prev_r;
    // Measures each lit and dark run of the lamp in clock cycles
    always_ff @(posedge clk or negedge reset_n)
        if (!reset_n)
        begin
            run_r <= 32'h0;
            prev_r <= 1'b0;
            lit_len <= 32'h0;
            dark_len <= 32'h0;
            edges <= 32'h0;
        end
        else if (lamp_lit !== prev_r)
        begin
            if (prev_r)
                lit_len <= run_r;
            else
                dark_len <= run_r;
            run_r <= 32'h1;
            prev_r <= lamp_lit;
            edges <= edges + 32'h1;
        end
        else
            run_r <= run_r + 32'h1;
endmodule

// ===== verification/ledbk_properties.sv
`timescale 1ns/1ps
`include "ledbk_regs.svh"
module ledbk_properties (
    input wire logic CLK, // Clock
    input wire logic RESET_N, // Reset
    input wire logic PSEL, // Select
    input wire logic PENABLE, // Access phase
    input wire logic PWRITE, // Direction
    input wire logic [17:0] PADDR, // Byte address
    input wire logic [31:0] PWDATA, // Write data
    input wire logic [31:0] PRDATA, // Read data
    input wire logic PREADY, // Ready
    input wire logic PSLVERR, // Error
    input wire ledbk_pkg::ledbk_phy_t PHY_STATUS, // Link status
    input wire logic IND_B_LIT // Indicator
);
    import ledbk_pkg::*;
    logic [15:0] ctrl_sh_r;
    logic mapped;
    logic steady_only;
    logic steady_on;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    // Shadow of the control register, updated by completed writes
    always_ff @(posedge CLK or negedge RESET_N)
        if (!RESET_N)
            ctrl_sh_r <= `LEDBK_CTRL_RST;
        else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == {`LEDBK_IDX_CTRL, 2'b00})
            ctrl_sh_r <= PWDATA[15:0] & `LEDBK_CTRL_WMASK;
    // Decode and lamp level when only steady sources are enabled
    assign mapped = PADDR[17:2] >= `LEDBK_IDX_COMMON && PADDR[17:2] <= `LEDBK_IDX_STATUS;
    assign steady_only = !ctrl_sh_r[15] && ctrl_sh_r[9:6] == 4'h0 && ctrl_sh_r[3:1] == 3'h0;
    assign steady_on = PHY_STATUS.link_up && (ctrl_sh_r[11] && PHY_STATUS.full_duplex
        || ctrl_sh_r[10] && !PHY_STATUS.full_duplex || ctrl_sh_r[5] && PHY_STATUS.speed_100
        || ctrl_sh_r[4] && !PHY_STATUS.speed_100);
    chk_ready_wait: assert property (!PENABLE ##1 (PSEL && PENABLE) |-> !PREADY ##1 PREADY)
        else $error("ready not after one wait state");
    chk_ready_pulse: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    chk_idle_rdata: assert property (!PREADY |-> PRDATA == 32'h0)
        else $error("read data outside ready cycle");
    chk_error_decode: assert property (PREADY && PADDR[1:0] == 2'b00 |-> PSLVERR == !mapped)
        else $error("error flag does not match decode");
    chk_ctrl_readback: assert property (
        PREADY && !PWRITE && PADDR == {`LEDBK_IDX_CTRL, 2'b00} |-> PRDATA == {16'h0, ctrl_sh_r})
        else $error("control read differs from written value");
    chk_force_dark: assert property (ctrl_sh_r[15:13] == 3'b100 |=> !IND_B_LIT)
        else $error("forced off lamp lit");
    chk_force_lit: assert property (ctrl_sh_r[15:13] == 3'b101 |=> IND_B_LIT)
        else $error("forced on lamp dark");
    chk_link_dark: assert property (!PHY_STATUS.link_up && !ctrl_sh_r[15] |=> !IND_B_LIT)
        else $error("lamp lit with link down");
    chk_steady_level: assert property (steady_only |=> IND_B_LIT == $past(steady_on))
        else $error("steady lamp level wrong");
endmodule

// ===== verification/ledbk_top_tb.sv
`timescale 1ns/1ps
`include "ledbk_regs.svh"
module ledbk_top_tb;
    import ledbk_pkg::*;
    localparam int TICK = 10;
    logic clk;
    logic reset_n;
    logic psel;
    logic penable;
    logic pwrite;
    logic [17:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic ind_b_lit;
    ledbk_phy_t phy_status;
    logic [31:0] lit_len;
    logic [31:0] dark_len;
    logic [31:0] edges;
    logic [31:0] rd;
    logic err;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;

    ledbk_top #(.TICK_CYCLES(TICK)) ledbk_top_i (.CLK(clk), .RESET_N(reset_n), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .PHY_STATUS(phy_status), .IND_B_LIT(ind_b_lit));
    ledbk_lamp_model ledbk_lamp_model_i (.clk(clk), .reset_n(reset_n), .lamp_lit(ind_b_lit),
        .lit_len(lit_len), .dark_len(dark_len), .edges(edges));

    // Clock and hang guard
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            miscompares++;
            conclude();
        end
    end

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One bus transfer, held until ready is sampled
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic steady(input logic [15:0] ctrl, input logic [5:0] st, input logic exp);
        apb(1'b1, `LEDBK_IDX_CTRL, {16'h0, ctrl});
        phy_status <= ledbk_phy_t'(st);
        repeat (3) @(posedge clk);
        check({31'h0, ind_b_lit}, {31'h0, exp});
    endtask

    // Configure, then measure two whole runs of the lamp
    task automatic blink(input logic [15:0] rate, input logic [15:0] com, input logic [15:0] ctrl,
        input logic [5:0] st, input int pre, input logic [31:0] lit, input logic [31:0] dark);
        int n;
        logic [31:0] e0;
        apb(1'b1, `LEDBK_IDX_RATE, {16'h0, rate});
        apb(1'b1, `LEDBK_IDX_COMMON, {16'h0, com});
        apb(1'b1, `LEDBK_IDX_CTRL, {16'h0, ctrl});
        phy_status <= ledbk_phy_t'(st);
        repeat (pre) @(posedge clk);
        e0 = edges;
        n = 0;
        while (edges < e0 + 32'h4 && n < 30000)
        begin
            @(posedge clk);
            n++;
        end
        check({31'h0, edges >= e0 + 32'h4}, 32'h1);
        check(lit_len, lit * TICK);
        check(dark_len, dark * TICK);
    endtask

    // Main sequence
    initial
    begin
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 18'h0;
        pwdata = 32'h0;
        phy_status = ledbk_phy_t'(6'h0);
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        apb(1'b0, `LEDBK_IDX_RATE, 32'h0);
        check(rd, 32'h0000ec75);
        apb(1'b0, `LEDBK_IDX_CTRL, 32'h0);
        check(rd, 32'h00000310);
        apb(1'b1, `LEDBK_IDX_CTRL, 32'hffffffff);
        apb(1'b0, `LEDBK_IDX_CTRL, 32'h0);
        check(rd, 32'h0000fffe);
        apb(1'b0, 16'h40c8, 32'h0);
        check({31'h0, err}, 32'h1);
        steady(16'h0800, 6'b101000, 1'b1);
        steady(16'h0800, 6'b100000, 1'b0);
        steady(16'h0400, 6'b100000, 1'b1);
        steady(16'h0020, 6'b110000, 1'b1);
        steady(16'h0010, 6'b100000, 1'b1);
        steady(16'h0010, 6'b000000, 1'b0);
        steady(16'ha000, 6'b000000, 1'b1);
        steady(16'h8000, 6'b110000, 1'b0);
        steady(16'h0080, 6'b110010, 1'b1);
        phy_status <= ledbk_phy_t'(6'b110000);
        repeat (99) @(posedge clk);
        check({31'h0, ind_b_lit}, 32'h1);
        repeat (16) @(posedge clk);
        check({31'h0, ind_b_lit}, 32'h0);
        blink(16'hed75, 16'h000c, 16'hc000, 6'b000000, 0, 62, 63);
        blink(16'heca5, 16'h000c, 16'he000, 6'b000000, 0, 250, 250);
        blink(16'hee75, 16'h000c, 16'hc000, 6'b000000, 0, 62, 63);
        blink(16'he975, 16'h020c, 16'hc000, 6'b000000, 0, 160, 840);
        blink(16'hecd5, 16'h000c, 16'h0310, 6'b100010, 0, 62, 63);
        blink(16'hecd5, 16'h000c, 16'h1200, 6'b100010, 0, 62, 63);
        blink(16'hecd5, 16'h000c, 16'h0008, 6'b100100, 0, 62, 63);
        blink(16'hec7c, 16'h000c, 16'h0004, 6'b110000, 0, 125, 125);
        blink(16'hdc75, 16'h0020, 16'h0310, 6'b100010, 12000, 62, 63);
        apb(1'b0, `LEDBK_IDX_STATUS, 32'h0);
        check(rd & 32'h00000038, 32'h00000028);
        conclude();
    end
endmodule

bind ledbk_top ledbk_properties ledbk_properties_i (.CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .PHY_STATUS(PHY_STATUS), .IND_B_LIT(IND_B_LIT));
